// *** logic/run_ctl_pkg.sv ***
package run_ctl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_SCREEN_VISIBLE = 8'h00;
  localparam logic [7:0] OFS_MENU_VIEW      = 8'h04;
  localparam logic [7:0] OFS_SCREEN_SOURCE  = 8'h08;
  localparam logic [7:0] OFS_DIGIT_SEP      = 8'h0C;
  localparam logic [7:0] OFS_NUM_FORMAT     = 8'h10;
  localparam logic [7:0] OFS_PRINT_EACH     = 8'h14;
  localparam logic [7:0] OFS_STOP_ON_FAIL   = 8'h18;
  localparam logic [7:0] OFS_RUN_REPEAT     = 8'h1C;
  localparam logic [7:0] OFS_COMMAND        = 8'h20;
  localparam logic [7:0] OFS_LIMIT_CLR_RUN  = 8'h24;
  localparam logic [7:0] OFS_AUTO_THRESHOLD = 8'h28;
  localparam logic [7:0] OFS_TRIGGER_MACRO  = 8'h2C;
  localparam logic [7:0] OFS_STATUS         = 8'h30;
  localparam logic [7:0] OFS_ERROR          = 8'h34;

  // command register bit positions
  localparam int CMD_SINGLE_SHOT = 0;
  localparam int CMD_ABORT       = 1;
  localparam int CMD_RESET       = 2;

  // values after reset command
  localparam logic RST_SCREEN_VISIBLE = 1'b1;
  localparam logic RST_MENU_VIEW      = 1'b0;
  localparam logic RST_SOURCE         = 1'b0;
  localparam logic RST_FORMAT         = 1'b0;
  localparam logic RST_PRINT_EACH     = 1'b0;
  localparam logic RST_STOP_ON_FAIL   = 1'b0;
  localparam logic RST_RUN_REPEAT     = 1'b0;
  // value at power-up
  localparam logic PWR_RUN_REPEAT     = 1'b1;

  // error codes
  localparam logic [15:0] ERR_NONE          = 16'h0000;
  localparam logic [15:0] ERR_INIT_IGNORED  = 16'hFF2B; // -213
  localparam logic [15:0] ERR_TRIGGER       = 16'hFF2E; // -210
  localparam logic [15:0] ERR_ILLEGAL_PARAM = 16'hFF20; // -224

  // not-a-number answer 9.91E37 as a 64-bit float
  localparam logic [63:0] NAN_BITS = $realtobits(9.91e37);

  // trigger macro actions
  typedef enum logic [1:0] {MACRO_NONE, MACRO_SINGLE, MACRO_ABORT} macro_t;

  // run states
  typedef enum logic [1:0] {ST_IDLE, ST_SINGLE, ST_CONT} run_st_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // query request to the response formatter, data query or other
  typedef struct packed {
    logic        valid;
    logic        is_data_query;
    logic        has_data;
    logic [63:0] value;
  } resp_req_t;

  // formatted response word
  typedef struct packed {
    logic        valid;
    logic        binary;
    logic [63:0] word;
  } resp_out_t;

endpackage

// *** logic/run_ctl.sv ***
`timescale 1ns/1ns

// Notes on behaviour
// - screen visibility flag, query 0/1, reset on
// - menu view only accepts off
// - screen source primary or statistics path
// - digit separator non-volatile, reset-proof
// - text format default, NaN when empty
// - binary format 64-bit float, NaN empty
// - format applies to data queries only
// - display settings never touch response data
// - group trigger runs stored trigger macro
// - print each result, stats, fail marks
// - limit fail clears run repeat if enabled
// - only single shot starts while run repeat off
// - run repeat on starts, chains measurements
// - run repeat on resets statistics
// - optional limit clear on run repeat
// - auto threshold on run and each cycle
// - continuous running uses count of one
// - pending flag from first start to end
// - abort keeps run repeat, restarts if on
// - errors while single measurement busy
// - power-up on, reset command off
module run_ctl (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // register port
  input  wire run_ctl_pkg::reg_req_t  reg_req,
  output logic [31:0]                 reg_rdata,
  // measurement engine
  output logic                        meas_start,
  output logic                        meas_abort,
  input  wire logic                   meas_done,
  input  wire logic                   limit_fail,
  input  wire logic                   limit_test_on,
  input  wire logic                   stats_on,
  output logic                        stats_reset,
  output logic                        limit_clear,
  output logic                        auto_trigger,
  output logic                        force_count_one,
  output logic                        pending_op,
  // instrument bus events and front-panel menu key
  input  wire logic                   group_trigger,
  input  wire logic                   listen_addressed,
  input  wire logic                   menu_key,
  // display
  output logic                        screen_visible,
  output logic                        menu_view,
  output logic                        screen_source,
  output logic                        digit_sep,
  // non-volatile store
  input  wire logic                   nv_sep_in,
  output logic                        nv_sep_out,
  // printer
  output logic                        print_result,
  output logic                        print_stats,
  output logic                        print_fail_mark,
  // response formatter
  input  wire run_ctl_pkg::resp_req_t resp_req,
  output run_ctl_pkg::resp_out_t      resp_out,
  // error queue
  output logic                        err_pulse,
  output logic [15:0]                 err_code
);

  // all state of the block
  typedef struct packed {
    run_ctl_pkg::run_st_t run_st;    // measurement run state
    logic                 run_rep;   // run_repeat
    logic                 pending;   // pending-operation flag
    logic                 visible;   // screen visible
    logic                 menu;      // menu view active
    logic                 src;       // 0 primary, 1 statistics
    logic                 sep;       // 0 period, 1 european
    logic                 nv_ok;     // separator loaded from store
    logic                 fmt;       // 0 text, 1 binary
    logic                 prn;       // print each result
    logic                 stop_fail; // stop on limit fail
    logic                 lim_clr;   // limit clear on run
    logic                 auto_thr;  // auto threshold
    run_ctl_pkg::macro_t  macro;     // trigger macro action
    logic                 err;       // error pulse
    logic [15:0]          err_code;  // last error code
    logic                 start;     // start pulse
    logic                 abort;     // abort pulse
    logic                 st_rst;    // statistics reset pulse
    logic                 lclr;      // limit clear pulse
    logic                 atrig;     // auto trigger pulse
    logic [31:0]          rdata;     // read data
    run_ctl_pkg::resp_out_t resp;    // response word
  } state_t;

  state_t s_q;
  state_t s_d;

  // boolean argument check
  function automatic logic is_bool(input logic [31:0] v);
    is_bool = (v[31:1] == 31'h0000_0000);
  endfunction

  // address match for a write
  function automatic logic wr_hit(input run_ctl_pkg::reg_req_t r, input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  logic do_single; // single-shot request this cycle
  logic do_abort;  // abort request this cycle
  logic do_rst;    // reset command this cycle
  logic get_hit;   // group trigger while listening

  // command decode
  always_comb begin
    get_hit   = group_trigger && listen_addressed;
    do_single = (wr_hit(reg_req, run_ctl_pkg::OFS_COMMAND) && reg_req.wdata[run_ctl_pkg::CMD_SINGLE_SHOT])
              || (get_hit && s_q.macro == run_ctl_pkg::MACRO_SINGLE);
    do_abort  = (wr_hit(reg_req, run_ctl_pkg::OFS_COMMAND) && reg_req.wdata[run_ctl_pkg::CMD_ABORT])
              || (get_hit && s_q.macro == run_ctl_pkg::MACRO_ABORT);
    do_rst    = wr_hit(reg_req, run_ctl_pkg::OFS_COMMAND) && reg_req.wdata[run_ctl_pkg::CMD_RESET];
  end

  // next state
  always_comb begin
    s_d        = s_q;
    s_d.err    = 1'b0;
    s_d.start  = 1'b0;
    s_d.abort  = 1'b0;
    s_d.st_rst = 1'b0;
    s_d.lclr   = 1'b0;
    s_d.atrig  = 1'b0;
    s_d.rdata  = 32'h0000_0000;
    s_d.resp.valid = 1'b0;

    // separator loaded once after power-up
    if (!s_q.nv_ok) begin
      s_d.sep   = nv_sep_in;
      s_d.nv_ok = 1'b1;
    end

    // front-panel menu key
    if (menu_key) begin
      s_d.menu = 1'b1;
    end

    // boolean setting writes
    if (reg_req.wr && !is_bool(reg_req.wdata) && reg_req.addr != run_ctl_pkg::OFS_COMMAND
        && reg_req.addr != run_ctl_pkg::OFS_TRIGGER_MACRO) begin
      s_d.err      = 1'b1;
      s_d.err_code = run_ctl_pkg::ERR_ILLEGAL_PARAM;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        run_ctl_pkg::OFS_SCREEN_VISIBLE: s_d.visible = reg_req.wdata[0];
        run_ctl_pkg::OFS_MENU_VIEW: begin
          if (reg_req.wdata[0]) begin
            s_d.err      = 1'b1;
            s_d.err_code = run_ctl_pkg::ERR_ILLEGAL_PARAM;
          end else begin
            s_d.menu = menu_key; // a key press in the same cycle wins
          end
        end
        run_ctl_pkg::OFS_SCREEN_SOURCE: s_d.src       = reg_req.wdata[0];
        run_ctl_pkg::OFS_DIGIT_SEP:     s_d.sep       = reg_req.wdata[0];
        run_ctl_pkg::OFS_NUM_FORMAT:    s_d.fmt       = reg_req.wdata[0];
        run_ctl_pkg::OFS_PRINT_EACH:    s_d.prn       = reg_req.wdata[0];
        run_ctl_pkg::OFS_STOP_ON_FAIL:  s_d.stop_fail = reg_req.wdata[0];
        run_ctl_pkg::OFS_LIMIT_CLR_RUN: s_d.lim_clr   = reg_req.wdata[0];
        run_ctl_pkg::OFS_AUTO_THRESHOLD: s_d.auto_thr = reg_req.wdata[0];
        run_ctl_pkg::OFS_TRIGGER_MACRO: begin
          if (reg_req.wdata[31:2] == 30'h0000_0000 && reg_req.wdata[1:0] != 2'b11) begin
            s_d.macro = run_ctl_pkg::macro_t'(reg_req.wdata[1:0]);
          end else begin
            s_d.err      = 1'b1;
            s_d.err_code = run_ctl_pkg::ERR_ILLEGAL_PARAM;
          end
        end
        run_ctl_pkg::OFS_RUN_REPEAT: begin
          if (s_q.run_st == run_ctl_pkg::ST_SINGLE) begin
            // busy with a single measurement
            s_d.err      = 1'b1;
            s_d.err_code = reg_req.wdata[0] ? run_ctl_pkg::ERR_INIT_IGNORED : run_ctl_pkg::ERR_TRIGGER;
          end else if (reg_req.wdata[0]) begin
            s_d.run_rep = 1'b1;
            s_d.st_rst  = 1'b1;
            s_d.lclr    = s_q.lim_clr;
            s_d.atrig   = s_q.auto_thr;
          end else begin
            s_d.run_rep = 1'b0;
          end
        end
        default: begin
          // command and unmapped writes handled elsewhere or ignored
        end
      endcase
    end

    // measurement run sequencing
    case (s_q.run_st)
      run_ctl_pkg::ST_IDLE: begin
        if (s_d.run_rep && !do_rst) begin
          s_d.run_st  = run_ctl_pkg::ST_CONT;
          s_d.start   = 1'b1;
          s_d.pending = 1'b1;
        end else if (do_single && !do_rst) begin
          s_d.run_st  = run_ctl_pkg::ST_SINGLE;
          s_d.start   = 1'b1;
          s_d.pending = 1'b1;
          s_d.lclr    = s_q.lim_clr;
          s_d.atrig   = s_q.auto_thr;
        end
      end
      run_ctl_pkg::ST_SINGLE: begin
        if (do_single) begin
          s_d.err      = 1'b1;
          s_d.err_code = run_ctl_pkg::ERR_INIT_IGNORED;
        end
        if (do_abort || do_rst) begin
          s_d.abort   = 1'b1;
          s_d.run_st  = run_ctl_pkg::ST_IDLE;
          s_d.pending = 1'b0;
        end else if (meas_done) begin
          s_d.run_st  = run_ctl_pkg::ST_IDLE;
          s_d.pending = 1'b0;
        end
      end
      run_ctl_pkg::ST_CONT: begin
        if (do_single) begin
          s_d.err      = 1'b1;
          s_d.err_code = run_ctl_pkg::ERR_INIT_IGNORED;
        end
        // stop on limit failure
        if (limit_fail && limit_test_on && s_q.stop_fail) begin
          s_d.run_rep = 1'b0;
        end
        if (do_abort || do_rst) begin
          // abort keeps run_repeat; idle restarts next cycle
          s_d.abort   = 1'b1;
          s_d.run_st  = run_ctl_pkg::ST_IDLE;
          s_d.pending = 1'b0;
        end else if (meas_done) begin
          if (s_d.run_rep) begin
            s_d.start = 1'b1;
            s_d.atrig = s_q.auto_thr;
          end else begin
            s_d.run_st  = run_ctl_pkg::ST_IDLE;
            s_d.pending = 1'b0;
          end
        end
      end
      default: begin
        s_d.run_st = run_ctl_pkg::ST_IDLE;
      end
    endcase

    // reset command restores defaults; separator, limit clear, auto threshold and macro untouched
    if (do_rst) begin
      s_d.run_rep   = run_ctl_pkg::RST_RUN_REPEAT;
      s_d.visible   = run_ctl_pkg::RST_SCREEN_VISIBLE;
      s_d.menu      = run_ctl_pkg::RST_MENU_VIEW;
      s_d.src       = run_ctl_pkg::RST_SOURCE;
      s_d.fmt       = run_ctl_pkg::RST_FORMAT;
      s_d.prn       = run_ctl_pkg::RST_PRINT_EACH;
      s_d.stop_fail = run_ctl_pkg::RST_STOP_ON_FAIL;
      s_d.start     = 1'b0;
      s_d.st_rst    = 1'b0;
      s_d.lclr      = 1'b0;
      s_d.atrig     = 1'b0;
    end

    // register read, data one cycle later
    if (reg_req.rd) begin
      case (reg_req.addr)
        run_ctl_pkg::OFS_SCREEN_VISIBLE: s_d.rdata = {31'h0000_0000, s_q.visible};
        run_ctl_pkg::OFS_MENU_VIEW:      s_d.rdata = {31'h0000_0000, s_q.menu};
        run_ctl_pkg::OFS_SCREEN_SOURCE:  s_d.rdata = {31'h0000_0000, s_q.src};
        run_ctl_pkg::OFS_DIGIT_SEP:      s_d.rdata = {31'h0000_0000, s_q.sep};
        run_ctl_pkg::OFS_NUM_FORMAT:     s_d.rdata = {31'h0000_0000, s_q.fmt};
        run_ctl_pkg::OFS_PRINT_EACH:     s_d.rdata = {31'h0000_0000, s_q.prn};
        run_ctl_pkg::OFS_STOP_ON_FAIL:   s_d.rdata = {31'h0000_0000, s_q.stop_fail};
        run_ctl_pkg::OFS_RUN_REPEAT:     s_d.rdata = {31'h0000_0000, s_q.run_rep};
        run_ctl_pkg::OFS_LIMIT_CLR_RUN:  s_d.rdata = {31'h0000_0000, s_q.lim_clr};
        run_ctl_pkg::OFS_AUTO_THRESHOLD: s_d.rdata = {31'h0000_0000, s_q.auto_thr};
        run_ctl_pkg::OFS_TRIGGER_MACRO:  s_d.rdata = {30'h0000_0000, s_q.macro};
        run_ctl_pkg::OFS_STATUS:         s_d.rdata = {28'h000_0000, s_q.run_st, s_q.pending, s_q.run_rep};
        run_ctl_pkg::OFS_ERROR:          s_d.rdata = {16'h0000, s_q.err_code};
        default:                         s_d.rdata = 32'h0000_0000; // unmapped
      endcase
    end

    // response formatting, independent of display settings
    if (resp_req.valid) begin
      s_d.resp.valid  = 1'b1;
      s_d.resp.binary = s_q.fmt && resp_req.is_data_query;
      if (resp_req.is_data_query && !resp_req.has_data) begin
        s_d.resp.word = run_ctl_pkg::NAN_BITS;
      end else begin
        s_d.resp.word = resp_req.value;
      end
    end
  end

  // state register; power-up leaves run_repeat on
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.run_st    <= run_ctl_pkg::ST_IDLE;
      s_q.run_rep   <= run_ctl_pkg::PWR_RUN_REPEAT;
      s_q.visible   <= run_ctl_pkg::RST_SCREEN_VISIBLE;
      s_q.macro     <= run_ctl_pkg::MACRO_SINGLE;
      s_q.err_code  <= run_ctl_pkg::ERR_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign reg_rdata       = s_q.rdata;
  assign meas_start      = s_q.start;
  assign meas_abort      = s_q.abort;
  assign stats_reset     = s_q.st_rst;
  assign limit_clear     = s_q.lclr;
  assign auto_trigger    = s_q.atrig;
  assign force_count_one = (s_q.run_st == run_ctl_pkg::ST_CONT);
  assign pending_op      = s_q.pending;
  assign screen_visible  = s_q.visible;
  assign menu_view       = s_q.menu;
  assign screen_source   = s_q.src;
  assign digit_sep       = s_q.sep;
  assign nv_sep_out      = s_q.sep;
  assign print_result    = s_q.prn;
  assign print_stats     = s_q.prn && stats_on;
  assign print_fail_mark = s_q.prn && limit_test_on;
  assign resp_out        = s_q.resp;
  assign err_pulse       = s_q.err;
  assign err_code        = s_q.err_code;

  // checks
  a_run_on_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.run_st == run_ctl_pkg::ST_IDLE && !s_q.run_rep && reg_req.wr
     && reg_req.addr == run_ctl_pkg::OFS_RUN_REPEAT && reg_req.wdata == 32'h0000_0001)
    |=> meas_start) else $error("run repeat on did not start");

  a_stats_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.run_st != run_ctl_pkg::ST_SINGLE && reg_req.wr && reg_req.addr == run_ctl_pkg::OFS_RUN_REPEAT
     && reg_req.wdata == 32'h0000_0001) |=> stats_reset) else $error("no statistics reset");

  a_idle_no_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.run_st == run_ctl_pkg::ST_IDLE && !s_q.run_rep && !do_single && !reg_req.wr)
    |=> !meas_start) else $error("start while run repeat off");

  a_single_busy_err: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.run_st == run_ctl_pkg::ST_SINGLE && reg_req.wr && reg_req.addr == run_ctl_pkg::OFS_RUN_REPEAT
     && reg_req.wdata == 32'h0000_0001) |=> err_pulse && err_code == 16'hFF2B && !s_q.run_rep)
    else $error("missing init ignored error");

  a_abort_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.run_st == run_ctl_pkg::ST_CONT && do_abort && !do_rst && !limit_fail
     && !(reg_req.wr && reg_req.addr != run_ctl_pkg::OFS_COMMAND))
    |=> meas_abort && !pending_op && $stable(s_q.run_rep) ##1 (meas_start == s_q.run_rep))
    else $error("abort handling wrong");

  a_limit_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.run_st == run_ctl_pkg::ST_CONT && limit_fail && limit_test_on && s_q.stop_fail)
    |=> !s_q.run_rep) else $error("limit fail did not stop");

  a_bad_bool: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_req.wr && reg_req.addr == run_ctl_pkg::OFS_SCREEN_VISIBLE && !is_bool(reg_req.wdata) && !do_rst)
    |=> err_pulse && $stable(screen_visible)) else $error("bad boolean accepted");

  a_pend_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.run_st == run_ctl_pkg::ST_CONT && meas_done && !s_d.run_rep && !do_abort && !do_rst)
    |=> !pending_op) else $error("pending flag stuck");

  a_nan_resp: assert property (@(posedge core_clk) disable iff (!rst_n)
    (resp_req.valid && resp_req.is_data_query && !resp_req.has_data)
    |=> resp_out.valid && resp_out.word == run_ctl_pkg::NAN_BITS && resp_out.binary == $past(s_q.fmt))
    else $error("no-data answer not NaN");

  c_cont_chain: cover property (@(posedge core_clk) disable iff (!rst_n)
    s_q.run_st == run_ctl_pkg::ST_CONT && meas_done ##1 meas_start);
  c_single_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    s_q.run_st == run_ctl_pkg::ST_SINGLE ##[1:20] meas_done);
  c_get_fire: cover property (@(posedge core_clk) disable iff (!rst_n) get_hit);

endmodule // run_ctl

// *** dv/meas_engine_model.sv ***
`timescale 1ns/1ns

// measurement engine: ends each started, unaborted measurement after a varying delay
module meas_engine_model #(
  parameter int MIN_DLY = 12
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // control from the block
  input  wire logic meas_start,
  input  wire logic meas_abort,
  // completion back to the block
  output logic      meas_done
);
  int cnt; // cycles left, 0 when idle

  // count down; an abort drops the running measurement without a done
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= (cnt == 1) && !meas_abort;
      if (meas_abort) begin
        cnt <= 0;
      end else if (meas_start) begin
        cnt <= MIN_DLY + int'($urandom_range(7));
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // meas_engine_model

// *** dv/measurement_run_and_output_control_tb.sv ***
`timescale 1ns/1ns

module measurement_run_and_output_control_tb;
  logic                   core_clk, rst_n, meas_start, meas_abort, meas_done, limit_fail, limit_test_on;
  logic                   stats_on, stats_reset, limit_clear, auto_trigger, force_count_one, pending_op;
  logic                   group_trigger, listen_addressed, menu_key, screen_visible, menu_view;
  logic                   screen_source, digit_sep, nv_sep_in, nv_sep_out, print_result, print_stats;
  logic                   print_fail_mark, err_pulse;
  logic [31:0]            reg_rdata;
  logic [15:0]            err_code;
  run_ctl_pkg::reg_req_t  reg_req;
  run_ctl_pkg::resp_req_t resp_req;
  run_ctl_pkg::resp_out_t resp_out;
  int                     fail_count, num_checks, cyc, n_st, n_ab, n_sr, n_lc, n_at, s0, a0;
  int                     expv [int]; // reference register contents
  logic [63:0]            val;

  run_ctl dut_u (.core_clk, .rst_n, .reg_req, .reg_rdata, .meas_start, .meas_abort, .meas_done, .limit_fail,
    .limit_test_on, .stats_on, .stats_reset, .limit_clear, .auto_trigger, .force_count_one, .pending_op,
    .group_trigger, .listen_addressed, .menu_key, .screen_visible, .menu_view, .screen_source, .digit_sep,
    .nv_sep_in, .nv_sep_out, .print_result, .print_stats, .print_fail_mark, .resp_req, .resp_out, .err_pulse,
    .err_code);
  meas_engine_model eng_u (.core_clk, .rst_n, .meas_start, .meas_abort, .meas_done);

  // clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // pulse counters and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    n_st <= n_st + int'(meas_start);
    n_ab <= n_ab + int'(meas_abort);
    n_sr <= n_sr + int'(stats_reset);
    n_lc <= n_lc + int'(limit_clear);
    n_at <= n_at + int'(auto_trigger);
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // register write; refused values must leave the model alone and flag an error
  task automatic wr(logic [7:0] a, int v);
    bit ok;
    ok = (a == 8'h04) ? (v == 0) : (a == 8'h2c) ? (v < 3) : (v <= 1) || (a == 8'h20);
    @(posedge core_clk);
    reg_req <= '{a, 32'(v), 1'b1, 1'b0};
    @(posedge core_clk);
    reg_req <= '{a, 32'(v), 1'b0, 1'b0};
    #1;
    if (ok && a != 8'h20) expv[a] = v;
    if (!ok) chk("err_code", 64'(run_ctl_pkg::ERR_ILLEGAL_PARAM), 64'(err_code));
    if (!ok) chk("err_pulse", 1, 64'(err_pulse));
  endtask

  // register read compared with the model
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    reg_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_req <= '{a, 32'h0000_0000, 1'b0, 1'b0};
    #1;
    chk($sformatf("reg %h", a), 64'(expv.exists(a) ? expv[a] : 0), 64'(reg_rdata));
  endtask

  task automatic wait_pend(logic v);
    for (int k = 0; k < 200 && pending_op !== v; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("pending_op", 64'(v), 64'(pending_op));
  endtask

  // main sequence
  initial begin
    void'($urandom(71));
    {rst_n, limit_fail, limit_test_on, stats_on, group_trigger, listen_addressed, menu_key} = '0;
    {reg_req, resp_req} = '0;
    nv_sep_in = 1'b1;
    {fail_count, num_checks, cyc, n_st, n_ab, n_sr, n_lc, n_at} = '0;
    expv = '{8'h00: 1, 8'h0c: 1, 8'h1c: 1, 8'h2c: 1};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("start after power-up", 1, 64'(n_st));
    chk("pending_op", 1, 64'(pending_op));
    foreach (expv[a]) rd(8'(a));
    // nondefault settings, then the reset command
    for (int a = 0; a <= 'h18; a += 4) if (a != 'h0c) wr(8'(a), (a <= 'h04) ? 0 : 1);
    @(posedge core_clk);
    menu_key <= 1'b1;
    @(posedge core_clk);
    menu_key <= 1'b0;
    wr(run_ctl_pkg::OFS_COMMAND, 4);
    expv = '{8'h00: 1, 8'h04: 0, 8'h08: 0, 8'h0c: 1, 8'h10: 0, 8'h14: 0, 8'h18: 0, 8'h1c: 0, 8'h2c: 1};
    foreach (expv[a]) rd(8'(a));
    chk("digit_sep", 1, 64'(digit_sep));
    chk("display pins", 64'h13, 64'({screen_visible, menu_view, screen_source, digit_sep, nv_sep_out}));
    wait_pend(1'b0);
    s0 = n_st;
    repeat (30) @(posedge core_clk);
    chk("idle starts", 64'(s0), 64'(n_st));
    wr(8'h00, 2);
    wr(8'h04, 1);
    rd(8'h00);
    @(posedge core_clk);
    menu_key <= 1'b1;
    @(posedge core_clk);
    menu_key <= 1'b0;
    expv[8'h04] = 1;
    rd(8'h04);
    wr(8'h04, 0);
    rd(8'h04);
    // single shot, run control requests while busy
    wr(run_ctl_pkg::OFS_COMMAND, 1);
    @(posedge core_clk);
    #1;
    chk("single start", 64'(s0 + 1), 64'(n_st));
    wr(8'h1c, 1);
    chk("err_code", 64'(run_ctl_pkg::ERR_INIT_IGNORED), 64'(err_code));
    wr(8'h1c, 0);
    chk("err_code", 64'(run_ctl_pkg::ERR_TRIGGER), 64'(err_code));
    expv[8'h1c] = 0;
    rd(8'h1c);
    wait_pend(1'b0);
    // continuous running with limit clear and auto threshold
    wr(8'h24, 1);
    wr(8'h28, 1);
    {s0, a0} = {n_st, n_at};
    wr(8'h1c, 1);
    expv[8'h1c] = 1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("stats_reset", 1, 64'(n_sr));
    chk("limit_clear", 1, 64'(n_lc));
    chk("force_count_one", 1, 64'(force_count_one));
    for (int k = 0; k < 400 && n_st < s0 + 3; k++) @(posedge core_clk);
    #1;
    chk("chained starts", 1, 64'(n_st >= s0 + 3));
    chk("auto per start", 1, 64'(n_at - a0 >= n_st - s0));
    wr(run_ctl_pkg::OFS_COMMAND, 2);
    {s0, a0} = {n_st, n_ab};
    repeat (3) @(posedge core_clk);
    #1;
    chk("meas_abort", 64'(a0 + 1), 64'(n_ab));
    chk("restart", 64'(s0 + 1), 64'(n_st));
    rd(8'h1c);
    // stop on limit failure, printing outputs
    wr(8'h18, 1);
    wr(8'h14, 1);
    @(posedge core_clk);
    {limit_test_on, stats_on, limit_fail} <= 3'b111;
    @(posedge core_clk);
    limit_fail <= 1'b0;
    #1;
    chk("print", 64'h7, 64'({print_result, print_stats, print_fail_mark}));
    expv[8'h1c] = 0;
    rd(8'h1c);
    wait_pend(1'b0);
    // group trigger runs the stored macro only while listening
    s0 = n_st;
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      {group_trigger, listen_addressed} <= {1'b1, k[0]};
      @(posedge core_clk);
      group_trigger <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("macro start", 64'(s0 + k), 64'(n_st));
    end
    wr(8'h2c, 3);
    wait_pend(1'b0);
    // response formats over every combination, display routing varied
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, i % 2);
      wr(8'h08, int'($urandom_range(1)));
      val = {$urandom, $urandom};
      @(posedge core_clk);
      resp_req <= '{1'b1, i[1], i[2], val};
      @(posedge core_clk);
      resp_req <= '0;
      #1;
      chk("resp valid", 1, 64'(resp_out.valid));
      chk("resp binary", 64'(i[0] & i[1]), 64'(resp_out.binary));
      chk("resp word", (i[1] && !i[2]) ? $realtobits(9.91e37) : val, resp_out.word);
    end
    print_verdict();
  end
endmodule // measurement_run_and_output_control_tb
